//--- common/lesu_pkg.sv
package lesu_pkg;
    localparam int unsigned LESU_DW = 32;
    localparam int unsigned LESU_AW = 8;
    localparam int unsigned LESU_SW = 4;
    localparam logic [7:0] LESU_OFS_STATUS = 8'h10;
    localparam logic [7:0] LESU_OFS_MASK = 8'h14;
    localparam logic [7:0] LESU_OFS_CTRL = 8'h40;
    localparam logic [31:0] LESU_IMPL_BITS = 32'hBFC76000;
    localparam logic [31:0] LESU_STATUS_RST = 32'h00000000;
    localparam logic [31:0] LESU_MASK_RST = 32'h00000000;
    localparam logic [31:0] LESU_ZERO_WORD = 32'h00000000;
    localparam int unsigned LESU_B_ISO_STUCK = 13;
    localparam int unsigned LESU_B_ASYNC_STUCK = 14;
    localparam int unsigned LESU_B_BUSY_ACK = 16;
    localparam int unsigned LESU_B_HDR_CRC = 17;
    localparam int unsigned LESU_B_TCODE = 18;
    localparam int unsigned LESU_B_CYC_SEC = 22;
    localparam int unsigned LESU_B_CYC_START = 23;
    localparam int unsigned LESU_B_CYC_DONE = 24;
    localparam int unsigned LESU_B_CYC_PEND = 25;
    localparam int unsigned LESU_B_CYC_LOST = 26;
    localparam int unsigned LESU_B_CYC_ARB = 27;
    localparam int unsigned LESU_B_ARB_GAP = 28;
    localparam int unsigned LESU_B_SUB_GAP = 29;
    localparam int unsigned LESU_B_ISO_ARB = 31;
    localparam int unsigned LESU_CTRL_SRST_BIT = 0;
    localparam int unsigned LESU_CTRL_MASTER_BIT = 1;
    localparam logic [1:0] LESU_LOST_WRAPS = 2'h2;
    localparam logic [1:0] LESU_WRAP_ONE = 2'h1;
    localparam logic [1:0] LESU_WRAP_NONE = 2'h0;
endpackage : lesu_pkg

//--- common/lesu_cyc_if.sv
`timescale 1ns/1ns
interface lesu_cyc_if;
    logic cycle_master;
    logic num_adv;
    logic start_rx;
    logic gap;
    logic wrap;
    logic pend_set;
    logic pend_clr;
    logic lost_set;
    modport trk (
        input cycle_master, num_adv, start_rx, gap, wrap,
        output pend_set, pend_clr, lost_set
    );
    modport top (
        output cycle_master, num_adv, start_rx, gap, wrap,
        input pend_set, pend_clr, lost_set
    );
endinterface : lesu_cyc_if

//--- hw/lesu_sticky.sv
`timescale 1ns/1ns
module lesu_sticky (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cen,
    input wire logic srst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= 1'b0;
        end else if (cen) begin
            if (srst) begin
                q <= 1'b0;
            end else if (set) begin
                q <= 1'b1;
            end else if (clr) begin
                q <= 1'b0;
            end
        end
    end

    property p_set_wins;
        @(posedge clock) disable iff (!nrst) (cen && set && clr && !srst) |=> q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
endmodule : lesu_sticky

//--- hw/lesu_cyc_track.sv
`timescale 1ns/1ns
module lesu_cyc_track
    import lesu_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic cen,
    input wire logic srst,
    lesu_cyc_if.trk cif
);
    logic [1:0] wrap_cnt_r;
    logic last_wrap;

    assign cif.pend_set = cif.num_adv | (~cif.cycle_master & cif.start_rx);
    assign cif.pend_clr = cif.gap;
    assign last_wrap = (wrap_cnt_r == (LESU_LOST_WRAPS - LESU_WRAP_ONE));
    assign cif.lost_set = cif.wrap & ~cif.cycle_master & ~cif.start_rx & last_wrap;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrap_cnt_r <= LESU_WRAP_NONE;
        end else if (cen) begin
            if (srst || cif.cycle_master || cif.start_rx) begin
                wrap_cnt_r <= LESU_WRAP_NONE;
            end else if (cif.wrap) begin
                wrap_cnt_r <= last_wrap ? LESU_WRAP_NONE : wrap_cnt_r + LESU_WRAP_ONE;
            end
        end
    end

    property p_lost_two;
        @(posedge clock) disable iff (!nrst)
            cif.lost_set |-> (wrap_cnt_r == LESU_WRAP_ONE) && !cif.cycle_master;
    endproperty
    a_lost_two: assert property (p_lost_two) else $error("lost after wrong wrap count");
endmodule : lesu_cyc_track

//--- hw/lesu_top.sv
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module lesu_top
    import lesu_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic cen,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [LESU_AW-1:0] wb_adr_i,
    input wire logic [LESU_SW-1:0] wb_sel_i,
    input wire logic [LESU_DW-1:0] wb_dat_i,
    output logic [LESU_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cycle_master,
    input wire logic ev_iso_tx_fifo_stuck,
    input wire logic ev_async_tx_fifo_stuck,
    input wire logic ev_busy_ack_sent,
    input wire logic ev_header_crc_error,
    input wire logic ev_tx_tcode_error,
    input wire logic ev_cycle_seconds_tick,
    input wire logic ev_cycle_start_tx,
    input wire logic ev_cycle_start_rx,
    input wire logic ev_cycle_period_done,
    input wire logic ev_cycle_num_adv,
    input wire logic ev_cycle_timer_wrap,
    input wire logic ev_cycle_start_arb_fail,
    input wire logic ev_arb_reset_gap_seen,
    input wire logic ev_subaction_gap_seen,
    input wire logic ev_iso_arb_fail,
    output logic link_irq
);
    ////////////////////////////////////////////////////////////////
    // bus slave state

    logic ack_r;
    logic [LESU_DW-1:0] rdata_r;
    logic [LESU_DW-1:0] interrupt_mask_r;
    logic soft_rst_r;
    logic irq_r;
    logic [LESU_DW-1:0] interrupt_status;
    logic [LESU_DW-1:0] set_vec;
    logic [LESU_DW-1:0] clr_vec;
    logic [LESU_DW-1:0] byte_en;
    logic [LESU_DW-1:0] w1c_vec;
    logic [LESU_DW-1:0] rdata_nxt;
    logic req;
    logic wr_take;
    logic hit_status;
    logic hit_mask;
    logic hit_ctrl;

    lesu_cyc_if cif ();

    assign req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master sees ack
    assign wr_take = req & wb_we_i & ack_r;
    assign hit_status = (wb_adr_i == LESU_OFS_STATUS);
    assign hit_mask = (wb_adr_i == LESU_OFS_MASK);
    assign hit_ctrl = (wb_adr_i == LESU_OFS_CTRL);
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign link_irq = irq_r;

    always_comb begin
        byte_en = LESU_ZERO_WORD;
        for (int b = 0; b < LESU_SW; b++) begin
            byte_en[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    assign w1c_vec = (wr_take && hit_status) ? (wb_dat_i & byte_en & LESU_IMPL_BITS)
                                             : LESU_ZERO_WORD;

    always_comb begin
        rdata_nxt = LESU_ZERO_WORD;
        if (hit_status) begin
            rdata_nxt = interrupt_status;
        end else if (hit_mask) begin
            rdata_nxt = interrupt_mask_r;
        end else if (hit_ctrl) begin
            rdata_nxt[LESU_CTRL_MASTER_BIT] = cycle_master;
        end
    end

    ////////////////////////////////////////////////////////////////
    // handshake
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else if (cen) begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= LESU_ZERO_WORD;
        end else if (cen) begin
            if (req && !ack_r) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // mask and control
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            interrupt_mask_r <= LESU_MASK_RST;
        end else if (cen) begin
            if (wr_take && hit_mask) begin
                interrupt_mask_r <= ((interrupt_mask_r & ~byte_en)
                                     | (wb_dat_i & byte_en)) & LESU_IMPL_BITS;
            end
        end
    end

    // self-clearing software reset pulse
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            soft_rst_r <= 1'b0;
        end else if (cen) begin
            soft_rst_r <= wr_take & hit_ctrl & wb_sel_i[0] & wb_dat_i[LESU_CTRL_SRST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // cycle bookkeeping
    assign cif.cycle_master = cycle_master;
    assign cif.num_adv = ev_cycle_num_adv;
    assign cif.start_rx = ev_cycle_start_rx;
    assign cif.gap = ev_subaction_gap_seen;
    assign cif.wrap = ev_cycle_timer_wrap;

    lesu_cyc_track u_cyc (
        .clock(clock),
        .nrst(nrst),
        .cen(cen),
        .srst(soft_rst_r),
        .cif(cif)
    );

    ////////////////////////////////////////////////////////////////
    // event routing
    always_comb begin
        set_vec = LESU_ZERO_WORD;
        set_vec[LESU_B_ISO_STUCK] = ev_iso_tx_fifo_stuck;
        set_vec[LESU_B_ASYNC_STUCK] = ev_async_tx_fifo_stuck;
        set_vec[LESU_B_BUSY_ACK] = ev_busy_ack_sent;
        set_vec[LESU_B_HDR_CRC] = ev_header_crc_error;
        set_vec[LESU_B_TCODE] = ev_tx_tcode_error;
        set_vec[LESU_B_CYC_SEC] = ev_cycle_seconds_tick;
        set_vec[LESU_B_CYC_START] = ev_cycle_start_tx | ev_cycle_start_rx;
        set_vec[LESU_B_CYC_DONE] = ev_cycle_period_done;
        set_vec[LESU_B_CYC_PEND] = cif.pend_set;
        set_vec[LESU_B_CYC_LOST] = cif.lost_set;
        set_vec[LESU_B_CYC_ARB] = ev_cycle_start_arb_fail;
        set_vec[LESU_B_ARB_GAP] = ev_arb_reset_gap_seen;
        set_vec[LESU_B_SUB_GAP] = ev_subaction_gap_seen;
        set_vec[LESU_B_ISO_ARB] = ev_iso_arb_fail;
    end

    always_comb begin
        clr_vec = w1c_vec;
        clr_vec[LESU_B_CYC_PEND] = w1c_vec[LESU_B_CYC_PEND] | cif.pend_clr;
    end

    ////////////////////////////////////////////////////////////////
    // status bits
    for (genvar i = 0; i < LESU_DW; i++) begin : g_bit
        if (LESU_IMPL_BITS[i]) begin : g_used
            lesu_sticky u_bit (
                .clock(clock),
                .nrst(nrst),
                .cen(cen),
                .srst(soft_rst_r),
                .set(set_vec[i]),
                .clr(clr_vec[i]),
                .q(interrupt_status[i])
            );
        end else begin : g_unused
            assign interrupt_status[i] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else if (cen) begin
            irq_r <= |(interrupt_status & interrupt_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    logic live;
    assign live = cen & ~soft_rst_r;

    property p_ack_once;
        @(posedge clock) disable iff (!nrst) (cen && req && !ack_r) |=> ack_r;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("no ack after request");

    property p_ack_drop;
        @(posedge clock) disable iff (!nrst) (cen && ack_r) |=> !ack_r;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

    property p_iso_stuck;
        @(posedge clock) disable iff (!nrst)
            (live && ev_iso_tx_fifo_stuck) |=> interrupt_status[LESU_B_ISO_STUCK];
    endproperty
    a_iso_stuck: assert property (p_iso_stuck) else $error("bit 13 not set");

    property p_async_stuck;
        @(posedge clock) disable iff (!nrst)
            (live && ev_async_tx_fifo_stuck) |=> interrupt_status[LESU_B_ASYNC_STUCK];
    endproperty
    a_async_stuck: assert property (p_async_stuck) else $error("bit 14 not set");

    property p_busy_ack;
        @(posedge clock) disable iff (!nrst)
            (live && ev_busy_ack_sent) |=> interrupt_status[LESU_B_BUSY_ACK];
    endproperty
    a_busy_ack: assert property (p_busy_ack) else $error("bit 16 not set");

    property p_hdr_crc;
        @(posedge clock) disable iff (!nrst)
            (live && ev_header_crc_error) |=> interrupt_status[LESU_B_HDR_CRC];
    endproperty
    a_hdr_crc: assert property (p_hdr_crc) else $error("bit 17 not set");

    property p_tcode;
        @(posedge clock) disable iff (!nrst)
            (live && ev_tx_tcode_error) |=> interrupt_status[LESU_B_TCODE];
    endproperty
    a_tcode: assert property (p_tcode) else $error("bit 18 not set");

    property p_cyc_sec;
        @(posedge clock) disable iff (!nrst)
            (live && ev_cycle_seconds_tick) |=> interrupt_status[LESU_B_CYC_SEC];
    endproperty
    a_cyc_sec: assert property (p_cyc_sec) else $error("bit 22 not set");

    property p_cyc_start;
        @(posedge clock) disable iff (!nrst)
            (live && (ev_cycle_start_tx || ev_cycle_start_rx))
            |=> interrupt_status[LESU_B_CYC_START];
    endproperty
    a_cyc_start: assert property (p_cyc_start) else $error("bit 23 not set");

    property p_cyc_done;
        @(posedge clock) disable iff (!nrst)
            (live && ev_cycle_period_done) |=> interrupt_status[LESU_B_CYC_DONE];
    endproperty
    a_cyc_done: assert property (p_cyc_done) else $error("bit 24 not set");

    property p_pend_master;
        @(posedge clock) disable iff (!nrst)
            (live && cycle_master && ev_cycle_num_adv) |=> interrupt_status[LESU_B_CYC_PEND];
    endproperty
    a_pend_master: assert property (p_pend_master) else $error("bit 25 not set");

    property p_pend_slave;
        @(posedge clock) disable iff (!nrst)
            (live && !cycle_master && ev_cycle_start_rx)
            |=> interrupt_status[LESU_B_CYC_PEND];
    endproperty
    a_pend_slave: assert property (p_pend_slave) else $error("bit 25 missed start");

    property p_pend_gap;
        @(posedge clock) disable iff (!nrst)
            (live && ev_subaction_gap_seen && !cif.pend_set)
            |=> !interrupt_status[LESU_B_CYC_PEND];
    endproperty
    a_pend_gap: assert property (p_pend_gap) else $error("bit 25 kept past gap");

    property p_lost;
        @(posedge clock) disable iff (!nrst)
            (live && cif.lost_set) |=> interrupt_status[LESU_B_CYC_LOST];
    endproperty
    a_lost: assert property (p_lost) else $error("bit 26 not set");

    property p_cyc_arb;
        @(posedge clock) disable iff (!nrst)
            (live && ev_cycle_start_arb_fail) |=> interrupt_status[LESU_B_CYC_ARB];
    endproperty
    a_cyc_arb: assert property (p_cyc_arb) else $error("bit 27 not set");

    property p_arb_gap;
        @(posedge clock) disable iff (!nrst)
            (live && ev_arb_reset_gap_seen) |=> interrupt_status[LESU_B_ARB_GAP];
    endproperty
    a_arb_gap: assert property (p_arb_gap) else $error("bit 28 not set");

    property p_sub_gap;
        @(posedge clock) disable iff (!nrst)
            (live && ev_subaction_gap_seen) |=> interrupt_status[LESU_B_SUB_GAP];
    endproperty
    a_sub_gap: assert property (p_sub_gap) else $error("bit 29 not set");

    property p_iso_arb;
        @(posedge clock) disable iff (!nrst)
            (live && ev_iso_arb_fail) |=> interrupt_status[LESU_B_ISO_ARB];
    endproperty
    a_iso_arb: assert property (p_iso_arb) else $error("bit 31 not set");

    property p_w1c;
        @(posedge clock) disable iff (!nrst)
            (cen && w1c_vec[LESU_B_BUSY_ACK] && !ev_busy_ack_sent)
            |=> !interrupt_status[LESU_B_BUSY_ACK];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_w0_keeps;
        @(posedge clock) disable iff (!nrst)
            (live && wr_take && hit_status && interrupt_status[LESU_B_HDR_CRC]
             && !w1c_vec[LESU_B_HDR_CRC]) |=> interrupt_status[LESU_B_HDR_CRC];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared");

    property p_soft_rst;
        @(posedge clock) disable iff (!nrst)
            (cen && soft_rst_r) |=> (interrupt_status == LESU_STATUS_RST);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset left bits");

    property p_irq;
        @(posedge clock) disable iff (!nrst)
            cen |=> (irq_r == |($past(interrupt_status) & $past(interrupt_mask_r)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not mask gated");

    property p_unused;
        @(posedge clock) disable iff (!nrst)
            ((interrupt_status | interrupt_mask_r) & ~LESU_IMPL_BITS) == LESU_ZERO_WORD;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit nonzero");

    property p_set_beats_clr;
        @(posedge clock) disable iff (!nrst)
            (live && w1c_vec[LESU_B_ISO_ARB] && ev_iso_arb_fail)
            |=> interrupt_status[LESU_B_ISO_ARB];
    endproperty
    a_set_beats_clr: assert property (p_set_beats_clr) else $error("event lost");

    c_clear: cover property (@(posedge clock) disable iff (!nrst)
        interrupt_status[LESU_B_BUSY_ACK] ##1 w1c_vec[LESU_B_BUSY_ACK]);
    c_irq: cover property (@(posedge clock) disable iff (!nrst) $rose(irq_r));
    c_lost: cover property (@(posedge clock) disable iff (!nrst) cif.lost_set);
    c_pend_gap: cover property (@(posedge clock) disable iff (!nrst)
        interrupt_status[LESU_B_CYC_PEND] ##1 !interrupt_status[LESU_B_CYC_PEND]);
endmodule : lesu_top

//--- testbench/lesu_host.sv
`timescale 1ns/1ns
module lesu_host
    import lesu_pkg::*;
(
    input wire logic clock,
    input wire logic wb_ack_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [LESU_AW-1:0] wb_adr_i,
    output logic [LESU_SW-1:0] wb_sel_i,
    output logic [LESU_DW-1:0] wb_dat_i,
    output logic hung
);
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, hung} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
    end
    // one bus transfer; raises hung if no ack within 50 cycles
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) hung <= 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_dat_i <= ~d;
    endtask : xfer
endmodule : lesu_host

//--- testbench/lesu_top_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module lesu_top_bench import lesu_pkg::*; ;
    logic clock, nrst, master, cyc, stb, we, hung, ack, irq, run;
    logic [14:0] ev;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o, m, e, qe;
    logic [31:0] expq[$];
    int mismatches, checks, i, k;
    localparam int POS [15] = '{13, 14, 16, 17, 18, 22, 23, 23, 24, 25, 0, 27, 28, 29, 31};
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    lesu_host i_host (.clock(clock), .wb_ack_o(ack), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .hung(hung));
    lesu_top i_dut (.clock(clock), .nrst(nrst), .cen(run), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .cycle_master(master), .ev_iso_tx_fifo_stuck(ev[0]),
        .ev_async_tx_fifo_stuck(ev[1]), .ev_busy_ack_sent(ev[2]), .ev_header_crc_error(ev[3]),
        .ev_tx_tcode_error(ev[4]), .ev_cycle_seconds_tick(ev[5]), .ev_cycle_start_tx(ev[6]),
        .ev_cycle_start_rx(ev[7]), .ev_cycle_period_done(ev[8]), .ev_cycle_num_adv(ev[9]),
        .ev_cycle_timer_wrap(ev[10]), .ev_cycle_start_arb_fail(ev[11]),
        .ev_arb_reset_gap_seen(ev[12]), .ev_subaction_gap_seen(ev[13]),
        .ev_iso_arb_fail(ev[14]), .link_irq(irq));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        expq.push_back(x);
        i_host.xfer(1'b0, a, 32'h00000000, 4'hF);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic wrl(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        i_host.xfer(1'b1, a, d, s);
    endtask : wrl
    task automatic pulse(input logic [14:0] p);
        @(posedge clock);
        ev <= p;
        @(posedge clock);
        ev <= 15'h0000;
    endtask : pulse
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0) begin
            qe = (expq.size() > 0) ? expq.pop_front() : ~dat_o;
            `CHK("read data", qe, dat_o)
        end
    end
    always @(posedge hung) begin
        mismatches++;
        close_out();
    end
    initial begin
        {nrst, master, ev, mismatches, checks} = '0;
        run = 1'b1;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        m = $urandom(32'hFE25);
        rd(LESU_OFS_STATUS, 32'h00000000);
        rd(LESU_OFS_MASK, 32'h00000000);
        for (k = 0; k < 2; k++) begin
            master <= k[0];
            for (i = 0; i < 15; i++) begin
                pulse(15'h0001 << i);
                e = (i == 10) ? 32'h00000000 : (32'h00000001 << POS[i]);
                if (i == 7 && k == 0) e = e | 32'h02000000;
                rd(LESU_OFS_STATUS, e);
                wr(LESU_OFS_STATUS, e);
                rd(LESU_OFS_STATUS, 32'h00000000);
            end
        end
        $display("test single events done");
        master <= 1'b0;
        pulse(15'h0400);
        pulse(15'h0400);
        rd(LESU_OFS_STATUS, 32'h04000000);
        wr(LESU_OFS_STATUS, 32'hFFFFFFFF);
        pulse(15'h0400);
        pulse(15'h0080);
        pulse(15'h0400);
        rd(LESU_OFS_STATUS, 32'h02800000);
        pulse(15'h2000);
        rd(LESU_OFS_STATUS, 32'h20800000);
        wr(LESU_OFS_STATUS, 32'hFFFFFFFF);
        $display("test cycle tracking done");
        pulse(15'h7BFF);
        rd(LESU_OFS_STATUS, 32'hBBC76000);
        wr(LESU_OFS_STATUS, 32'h00010000);
        rd(LESU_OFS_STATUS, 32'hBBC66000);
        wr(LESU_OFS_STATUS, 32'hFFFFFFFF);
        ev <= 15'h0004;
        wr(LESU_OFS_STATUS, 32'h00010000);
        ev <= 15'h0000;
        rd(LESU_OFS_STATUS, 32'h00010000);
        $display("test clear rules done");
        wr(LESU_OFS_MASK, 32'hFFFFFFFF);
        rd(LESU_OFS_MASK, LESU_IMPL_BITS);
        wr(LESU_OFS_MASK, 32'h00010000);
        repeat (2) @(posedge clock);
        `CHK("irq on", 1'b1, irq)
        pulse(15'h0008);
        wr(LESU_OFS_STATUS, 32'h00010000);
        repeat (2) @(posedge clock);
        `CHK("irq masked", 1'b0, irq)
        m = $urandom;
        wr(LESU_OFS_MASK, m);
        rd(LESU_OFS_MASK, m & LESU_IMPL_BITS);
        $display("test mask done");
        // frozen clock enable must not take an event
        run <= 1'b0;
        pulse(15'h0004);
        run <= 1'b1;
        rd(LESU_OFS_STATUS, 32'h00020000);
        $display("test clock enable done");
        wr(LESU_OFS_CTRL, 32'h00000001);
        repeat (2) @(posedge clock);
        rd(LESU_OFS_STATUS, 32'h00000000);
        rd(LESU_OFS_MASK, m & LESU_IMPL_BITS);
        wrl(LESU_OFS_MASK, 32'h00000000, 4'h8);
        rd(LESU_OFS_MASK, m & LESU_IMPL_BITS & 32'h00FFFFFF);
        master <= 1'b1;
        rd(LESU_OFS_CTRL, 32'h00000002);
        rd(8'h20, 32'h00000000);
        repeat (3) @(posedge clock);
        `CHK("reads left", 0, expq.size())
        $display("test soft reset done");
        close_out();
    end
endmodule : lesu_top_bench
